// *** src/btr_target.sv ***
// Purpose: burst write and split completion target feeding a user write stream
// Assumes: bus signals are registered on MCLK, so they need no synchroniser
// Notes: reads are not claimed; the device range is set by two parameters
`timescale 1ns/1ns
`default_nettype none

module btr_target import btr_pkg::*; #(
	parameter logic [63:0] RANGE_BASE = 64'h0000_0000_0000_0000,
	parameter logic [63:0] RANGE_LIMIT = 64'h0000_0000_0000_ffff
) (
	input wire logic MCLK,
	input wire logic RST_N,
	input wire logic FRAME_N,
	input wire logic IRDY_N,
	input wire logic REQ64_N,
	input wire logic [63:0] AD_IN,
	input wire logic [7:0] CBE_IN_N,
	output logic DEVSEL_N,
	output logic TRDY_N,
	output logic STOP_N,
	output logic ACK64_N,
	output logic W_VALID,
	input wire logic W_READY,
	output var btr_word_t W_WORD
);
	btr_state_t state_reg, state_next;
	logic frame_d_reg, frame_d_next;
	logic is_mw_reg, is_mw_next;
	logic is_split_reg, is_split_next;
	logic wide_reg, wide_next;
	logic [63:0] addr_reg, addr_next;
	logic [12:0] rem_reg, rem_next;
	logic devsel_n_reg, devsel_n_next;
	logic trdy_n_reg, trdy_n_next;
	logic stop_n_reg, stop_n_next;
	logic ack64_n_reg, ack64_n_next;
	btr_word_t head_reg, head_next, spare_reg, spare_next;
	logic head_v_reg, head_v_next, spare_v_reg, spare_v_next;

	logic [3:0] cmd;
	logic addr_start, write_cmd, split_cmd, in_range, xfer, push, pop, last;
	logic [12:0] nb, bc_dec, rem_after, pr, pb;
	logic [63:0] addr_after, pa;
	logic [2:0] offs;
	logic [7:0] rmask;
	logic bnd;
	btr_word_t in_word;

	assign cmd = CBE_IN_N[3:0];
	assign addr_start = (state_reg == ST_IDLE) && frame_d_reg && !FRAME_N;
	assign write_cmd = (cmd == CMD_MEM_WRITE) || (cmd == CMD_MW_BLOCK) ||
		(cmd == CMD_ALIAS_MWB);
	assign split_cmd = (cmd == CMD_SPLIT_COMPL);
	assign in_range = (AD_IN >= RANGE_BASE) && (AD_IN <= RANGE_LIMIT);
	assign xfer = (state_reg == ST_DATA) && !trdy_n_reg && !IRDY_N;
	assign push = xfer;
	assign pop = head_v_reg && W_READY;
	assign bc_dec = ({CBE_IN_N[3:0], AD_IN[7:0]} == BC_ZERO) ? BC_FULL :
		{1'b0, CBE_IN_N[3:0], AD_IN[7:0]};

	// lane arithmetic for the phase now offered
	assign nb = btr_phase_bytes(addr_reg[2:0], wide_reg, rem_reg);
	assign offs = wide_reg ? addr_reg[2:0] : {1'b0, addr_reg[1:0]};
	assign rmask = btr_lane_mask(offs, nb);
	assign addr_after = addr_reg + {51'h0, nb};
	assign rem_after = rem_reg - nb;
	// enables change nothing in the count, only which bytes are written
	assign last = (rem_after == 13'h0000) || FRAME_N;

	always_comb begin
		in_word.addr = wide_reg ? {addr_reg[63:3], 3'h0} : {addr_reg[63:2], 2'h0};
		in_word.data = wide_reg ? AD_IN : {32'h0000_0000, AD_IN[31:0]};
		// out-of-range lanes are masked even for Memory Write, so a stray enable is harmless
		in_word.be = is_mw_reg ? (~CBE_IN_N & rmask) : rmask;
		in_word.split = is_split_reg;
		in_word.wide = wide_reg;
	end

	// two-entry buffer; head drives the stream straight from flops
	always_comb begin
		head_next = head_reg;
		spare_next = spare_reg;
		head_v_next = head_v_reg;
		spare_v_next = spare_v_reg;
		if (pop) begin
			if (spare_v_reg) begin
				head_next = spare_reg;
				spare_next = in_word;
				spare_v_next = push;
			end else begin
				head_next = in_word;
				head_v_next = push;
			end
		end else if (push) begin
			if (!head_v_reg) begin
				head_next = in_word;
				head_v_next = 1'b1;
			end else begin
				spare_next = in_word;
				spare_v_next = 1'b1;
			end
		end
	end

	// phase that will be offered next, and whether it must be the last before range end
	always_comb begin
		pa = addr_reg;
		pr = rem_reg;
		if (state_reg == ST_ATTR) begin
			pr = bc_dec;
		end else if (xfer) begin
			pa = addr_after;
			pr = rem_after;
		end
		pb = btr_phase_bytes(pa[2:0], wide_reg, pr);
		bnd = (pr > pb) && ((pa + {51'h0, pb} - ADDR_ONE) >= RANGE_LIMIT);
	end

	always_comb begin
		state_next = state_reg;
		frame_d_next = FRAME_N;
		is_mw_next = is_mw_reg;
		is_split_next = is_split_reg;
		wide_next = wide_reg;
		addr_next = addr_reg;
		rem_next = rem_reg;
		devsel_n_next = 1'b1;
		trdy_n_next = 1'b1;
		ack64_n_next = 1'b1;
		case (state_reg)
			ST_IDLE: begin
				if (addr_start && in_range && (write_cmd || split_cmd)) begin
					addr_next = AD_IN;
					is_mw_next = (cmd == CMD_MEM_WRITE);
					is_split_next = split_cmd;
					wide_next = !REQ64_N;
					state_next = ST_ATTR;
				end
			end
			ST_ATTR: begin
				rem_next = bc_dec;
				devsel_n_next = 1'b0;
				ack64_n_next = !wide_reg;
				trdy_n_next = head_v_next && spare_v_next;
				state_next = ST_DATA;
			end
			ST_DATA: begin
				devsel_n_next = 1'b0;
				ack64_n_next = ack64_n_reg;
				// wait state whenever the buffer cannot take the next word
				trdy_n_next = head_v_next && spare_v_next;
				if (xfer) begin
					addr_next = addr_after;
					rem_next = rem_after;
				end
				if ((xfer && (last || !stop_n_reg)) || (FRAME_N && IRDY_N)) begin
					devsel_n_next = 1'b1;
					trdy_n_next = 1'b1;
					ack64_n_next = 1'b1;
					state_next = ST_TURN;
				end
			end
			ST_TURN: begin
				state_next = ST_IDLE;
			end
			default: begin
				state_next = ST_IDLE;
			end
		endcase
		// stop only ever rides with data: no retry and no split response from this target
		stop_n_next = !(!trdy_n_next && bnd);
	end

	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			state_reg <= ST_IDLE;
			frame_d_reg <= 1'b1;
			is_mw_reg <= 1'b0;
			is_split_reg <= 1'b0;
			wide_reg <= 1'b0;
			addr_reg <= '0;
			rem_reg <= '0;
			devsel_n_reg <= 1'b1;
			trdy_n_reg <= 1'b1;
			stop_n_reg <= 1'b1;
			ack64_n_reg <= 1'b1;
			head_reg <= '0;
			spare_reg <= '0;
			head_v_reg <= 1'b0;
			spare_v_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			frame_d_reg <= frame_d_next;
			is_mw_reg <= is_mw_next;
			is_split_reg <= is_split_next;
			wide_reg <= wide_next;
			addr_reg <= addr_next;
			rem_reg <= rem_next;
			devsel_n_reg <= devsel_n_next;
			trdy_n_reg <= trdy_n_next;
			stop_n_reg <= stop_n_next;
			ack64_n_reg <= ack64_n_next;
			head_reg <= head_next;
			spare_reg <= spare_next;
			head_v_reg <= head_v_next;
			spare_v_reg <= spare_v_next;
		end
	end

	assign DEVSEL_N = devsel_n_reg;
	assign TRDY_N = trdy_n_reg;
	assign STOP_N = stop_n_reg;
	assign ACK64_N = ack64_n_reg;
	assign W_VALID = head_v_reg;
	assign W_WORD = head_reg;

	default clocking cb @(posedge MCLK); endclocking
	default disable iff (!RST_N);

	sequence s_claim;
		addr_start && in_range;
	endsequence
	sequence s_data_phase;
		!DEVSEL_N;
	endsequence

	chk_alias_claim: assert property ((s_claim and (cmd == CMD_ALIAS_MWB)) |->
		##2 s_data_phase)
		else $error("alias write block not claimed");
	chk_width_ack: assert property ((s_claim and write_cmd && !REQ64_N) |-> ##2 !ACK64_N)
		else $error("wide burst not acknowledged");
	chk_start_addr: assert property ((state_reg == ST_ATTR) |-> addr_reg == $past(AD_IN))
		else $error("start address not taken from full bus");
	chk_bc_zero: assert property ((state_reg == ST_ATTR &&
		{CBE_IN_N[3:0], AD_IN[7:0]} == BC_ZERO) |=> rem_reg == BC_FULL)
		else $error("zero byte count not 4096");
	chk_stop_trdy: assert property (!STOP_N |-> !TRDY_N && !DEVSEL_N)
		else $error("stop without data phase");
	chk_lane_natural: assert property ((xfer && wide_reg && !is_mw_reg) |->
		in_word.be[addr_reg[2:0]])
		else $error("start lane not natural");
	chk_full_bytes: assert property ((xfer && !is_mw_reg) |-> $countones(in_word.be) == nb)
		else $error("block write missing bytes");
	// checks the stream head the cycle after a write into an empty buffer, not just the lane mask
	chk_be_untouched: assert property ((xfer && is_mw_reg && !head_v_reg) |=>
		(W_WORD.be & $past(CBE_IN_N)) == 8'h00)
		else $error("disabled byte written");
	chk_disc_end: assert property ((xfer && !STOP_N) |=> DEVSEL_N && TRDY_N)
		else $error("boundary disconnect did not end burst");
	chk_count_end: assert property ((xfer && rem_reg == nb) |=>
		DEVSEL_N ##1 state_reg == ST_IDLE)
		else $error("burst ran past byte count");
	chk_cross_4g: assert property ((xfer && !last && STOP_N &&
		addr_reg[63:32] != addr_after[63:32]) |=> !DEVSEL_N)
		else $error("4 GB crossing ended burst");
	chk_buf_room: assert property (xfer |-> !(head_v_reg && spare_v_reg && !W_READY))
		else $error("buffer overrun");
endmodule

`default_nettype wire

// *** src/btr_pkg.sv ***
// Purpose: shared constants, types and helpers of the burst write target
// Assumes: 64-bit address, 64-bit data path with 32-bit fallback
// Notes: command codes sit here so that every user decodes them alike
`default_nettype none
package btr_pkg;
	localparam logic [3:0] CMD_MEM_WRITE = 4'h7;
	localparam logic [3:0] CMD_MW_BLOCK = 4'hf;
	localparam logic [3:0] CMD_ALIAS_MWB = 4'hb;
	localparam logic [3:0] CMD_SPLIT_COMPL = 4'hc;
	localparam logic [12:0] BC_FULL = 13'h1000;
	localparam logic [11:0] BC_ZERO = 12'h000;
	localparam logic [3:0] BYTES_WIDE = 4'h8;
	localparam logic [3:0] BYTES_NARROW = 4'h4;
	localparam logic [63:0] ADDR_ONE = 64'h0000_0000_0000_0001;

	typedef struct packed {
		logic [63:0] addr;
		logic [63:0] data;
		logic [7:0] be;
		logic split;
		logic wide;
	} btr_word_t;

	typedef enum logic [1:0] {ST_IDLE, ST_ATTR, ST_DATA, ST_TURN} btr_state_t;

	// bytes moved by the phase at this address: up to the bus-width edge, never past the count
	function automatic logic [12:0] btr_phase_bytes(input logic [2:0] a, input logic wide,
			input logic [12:0] rem);
		logic [3:0] avail;
		avail = wide ? (BYTES_WIDE - {1'b0, a}) : (BYTES_NARROW - {2'b00, a[1:0]});
		btr_phase_bytes = ({9'h000, avail} < rem) ? {9'h000, avail} : rem;
	endfunction

	function automatic logic [7:0] btr_lane_mask(input logic [2:0] offs, input logic [12:0] n);
		logic [7:0] m;
		m = 8'h00;
		for (int i = 0; i < 8; i++) begin
			m[i] = (i >= int'(offs)) && (i < int'(offs) + int'(n));
		end
		btr_lane_mask = m;
	endfunction
endpackage
`default_nettype wire

// *** sim/btr_init_model.sv ***
// Purpose: bus initiator model issuing burst writes to the target
// Assumes: phases change 1 ns after the rising edge
// Notes: gives up a phase after 40 edges without a transfer
`timescale 1ns/1ns
`default_nettype none
module btr_init_model import btr_pkg::*; (
	input wire logic MCLK,
	input wire logic DEVSEL_N,
	input wire logic TRDY_N,
	input wire logic STOP_N,
	output logic FRAME_N,
	output logic IRDY_N,
	output logic REQ64_N,
	output logic [63:0] AD_IN,
	output logic [7:0] CBE_IN_N
);
	initial begin
		FRAME_N = 1'b1;
		IRDY_N = 1'b1;
		REQ64_N = 1'b1;
		AD_IN = 64'h0;
		CBE_IN_N = 8'hff;
	end
	function automatic logic [7:0] lanes(input logic [3:0] off, input logic [3:0] n);
		logic [7:0] m;
		for (int i = 0; i < 8; i++) m[i] = (i >= off) && (i < off + n);
		return m;
	endfunction
	task automatic burst(input logic [3:0] cmd, input logic [63:0] a, input logic w,
			input logic [11:0] c, input logic [7:0] pat, output logic claimed);
		logic [12:0] rem;
		logic [63:0] aa;
		logic [3:0] off;
		logic [3:0] n;
		logic last;
		logic done;
		int t;
		rem = (c == 12'h000) ? 13'h1000 : {1'b0, c};
		claimed = 1'b0;
		done = 1'b0;
		@(posedge MCLK);
		#1;
		FRAME_N = 1'b0;
		AD_IN = a;
		CBE_IN_N = {4'hf, cmd};
		REQ64_N = !w;
		@(posedge MCLK);
		#1;
		AD_IN = {56'h0, c[7:0]};
		CBE_IN_N = {4'hf, c[11:8]};
		@(posedge MCLK);
		while (!done) begin
			off = w ? {1'b0, a[2:0]} : {2'b00, a[1:0]};
			n = (w ? 4'h8 : 4'h4) - off;
			if ({9'h000, n} > rem) n = rem[3:0];
			last = ({9'h000, n} == rem);
			aa = w ? {a[63:3], 3'b000} : {a[63:2], 2'b00};
			#1;
			FRAME_N = last;
			IRDY_N = 1'b0;
			AD_IN = {~aa[31:0], aa[31:0]};
			CBE_IN_N = (cmd == CMD_MEM_WRITE) ? ~(lanes(off, n) & pat) : 8'hff;
			t = 0;
			do begin
				@(posedge MCLK);
				t++;
				claimed |= !DEVSEL_N;
			end while (TRDY_N !== 1'b0 && t < 40);
			if (TRDY_N !== 1'b0) done = 1'b1;
			else begin
				a = a + {60'h0, n};
				rem = rem - {9'h000, n};
				done = last || !STOP_N;
			end
		end
		#1;
		FRAME_N = 1'b1;
		IRDY_N = 1'b1;
		REQ64_N = 1'b1;
		AD_IN = ~AD_IN;
		CBE_IN_N = 8'hff;
		repeat (2) @(posedge MCLK);
	endtask
endmodule
`default_nettype wire

// *** sim/burst_transaction_rules_tb.sv ***
// Purpose: self-checking bench of the burst write target
// Assumes: 64-bit is acknowledged whenever it is requested
// Notes: the range straddles 4 GB so crossing and range end share one instance
`timescale 1ns/1ns
`default_nettype none
module burst_transaction_rules_tb import btr_pkg::*;;
	localparam logic [63:0] BASE = 64'h0000_0000_ffff_ff00;
	localparam logic [63:0] LIM = 64'h0000_0001_0000_00ff;
	typedef struct packed {logic [3:0] cmd; logic [63:0] a; logic w; logic [11:0] c;
		logic [7:0] pat; logic [6:0] nw;} btr_row_t;
	btr_row_t rows[8] = '{
		'{CMD_MW_BLOCK, 64'h0000_0000_ffff_ff00, 1'b1, 12'h010, 8'hff, 7'h02},
		'{CMD_ALIAS_MWB, 64'h0000_0000_ffff_ff13, 1'b1, 12'h015, 8'hff, 7'h03},
		'{CMD_SPLIT_COMPL, 64'h0000_0000_ffff_ff21, 1'b0, 12'h00a, 8'hff, 7'h03},
		'{CMD_MEM_WRITE, 64'h0000_0000_ffff_ff05, 1'b1, 12'h014, 8'h5a, 7'h04},
		'{CMD_MEM_WRITE, 64'h0000_0000_ffff_ff42, 1'b0, 12'h009, 8'h00, 7'h03},
		'{CMD_MW_BLOCK, 64'h0000_0000_ffff_fffc, 1'b1, 12'h010, 8'hff, 7'h03},
		'{CMD_MW_BLOCK, 64'h0000_0001_0000_00f4, 1'b1, 12'h020, 8'hff, 7'h02},
		'{CMD_MW_BLOCK, 64'h0000_0000_ffff_ff00, 1'b1, 12'h000, 8'hff, 7'h40}};
	logic MCLK, RST_N, W_READY, stall, claimed, exp_w;
	logic FRAME_N, IRDY_N, REQ64_N, DEVSEL_N, TRDY_N, STOP_N, ACK64_N, W_VALID;
	logic [63:0] AD_IN;
	logic [7:0] CBE_IN_N;
	btr_word_t W_WORD;
	btr_word_t q[$];
	int n_fail, n_compared, n_words, n_base, cyc;
	btr_target #(.RANGE_BASE(BASE), .RANGE_LIMIT(LIM)) dut_u (.MCLK(MCLK), .RST_N(RST_N),
		.FRAME_N(FRAME_N), .IRDY_N(IRDY_N), .REQ64_N(REQ64_N), .AD_IN(AD_IN),
		.CBE_IN_N(CBE_IN_N), .DEVSEL_N(DEVSEL_N), .TRDY_N(TRDY_N), .STOP_N(STOP_N),
		.ACK64_N(ACK64_N), .W_VALID(W_VALID), .W_READY(W_READY), .W_WORD(W_WORD));
	btr_init_model ini_u (.MCLK(MCLK), .DEVSEL_N(DEVSEL_N), .TRDY_N(TRDY_N), .STOP_N(STOP_N),
		.FRAME_N(FRAME_N), .IRDY_N(IRDY_N), .REQ64_N(REQ64_N), .AD_IN(AD_IN),
		.CBE_IN_N(CBE_IN_N));
	task automatic chk(input logic ok, input string m);
		n_compared++;
		if (ok !== 1'b1) begin
			n_fail++;
			$display("wrong value at %0t ns: %s", $time, m);
		end
	endtask
	task automatic conclude();
		$display("compared %0d, wrong %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	task automatic expect_row(input btr_row_t r);
		logic [12:0] rem;
		logic [63:0] a;
		logic [3:0] off;
		logic [3:0] n;
		btr_word_t x;
		rem = (r.c == 12'h000) ? 13'h1000 : {1'b0, r.c};
		a = r.a;
		while (rem != 13'h0000 && a <= LIM) begin
			off = r.w ? {1'b0, a[2:0]} : {2'b00, a[1:0]};
			n = (r.w ? 4'h8 : 4'h4) - off;
			if ({9'h000, n} > rem) n = rem[3:0];
			x.addr = r.w ? {a[63:3], 3'b000} : {a[63:2], 2'b00};
			x.data = {r.w ? ~x.addr[31:0] : 32'h0, x.addr[31:0]};
			x.be = ini_u.lanes(off, n) & ((r.cmd == CMD_MEM_WRITE) ? r.pat : 8'hff);
			x.split = (r.cmd == CMD_SPLIT_COMPL);
			x.wide = r.w;
			q.push_back(x);
			a = a + {60'h0, n};
			rem = rem - {9'h000, n};
		end
	endtask
	task automatic drain();
		for (int k = 0; k < 80 && q.size() > 0; k++) @(posedge MCLK);
		repeat (2) @(posedge MCLK);
		chk(q.size() == 0, "words missing");
	endtask
	initial begin
		MCLK = 1'b0;
		forever #50 MCLK = ~MCLK;
	end
	// the receiver refuses every third cycle so the buffer is exercised throughout
	always begin
		@(posedge MCLK);
		#1;
		cyc++;
		W_READY = !stall && (cyc % 3 != 0);
	end
	always @(posedge MCLK) begin
		if (DEVSEL_N === 1'b0) chk(ACK64_N === !exp_w, "width ack");
		if (W_VALID === 1'b1 && W_READY === 1'b1) begin
			n_words++;
			if (q.size() == 0) chk(1'b0, "unexpected word");
			else chk(W_WORD === q.pop_front(), "stream word");
		end
	end
	initial begin
		#2_000_000;
		n_fail++;
		conclude();
	end
	initial begin
		RST_N = 1'b0;
		stall = 1'b0;
		exp_w = 1'b1;
		repeat (12) @(posedge MCLK);
		chk({DEVSEL_N, TRDY_N, STOP_N, ACK64_N, W_VALID} === 5'b11110, "reset outputs");
		chk(W_WORD === '0, "reset word");
		#1;
		RST_N = 1'b1;
		foreach (rows[i]) begin
			expect_row(rows[i]);
			n_base = n_words;
			exp_w = rows[i].w;
			ini_u.burst(rows[i].cmd, rows[i].a, rows[i].w, rows[i].c, rows[i].pat, claimed);
			drain();
			chk(claimed === 1'b1, "burst not claimed");
			chk(n_words - n_base == int'(rows[i].nw), "word count");
		end
		ini_u.burst(4'h6, BASE, 1'b1, 12'h008, 8'hff, claimed);
		chk(claimed === 1'b0, "read claimed");
		ini_u.burst(CMD_MW_BLOCK, LIM + 64'h1, 1'b1, 12'h008, 8'hff, claimed);
		chk(claimed === 1'b0, "out of range claimed");
		stall = 1'b1;
		expect_row(rows[7]);
		fork
			ini_u.burst(rows[7].cmd, rows[7].a, rows[7].w, rows[7].c, rows[7].pat, claimed);
			begin
				repeat (12) @(posedge MCLK);
				chk(TRDY_N === 1'b1 && W_VALID === 1'b1, "no wait while full");
				stall = 1'b0;
			end
		join
		drain();
		conclude();
	end
endmodule
`default_nettype wire
